// *** rtl/tpm_tap_port.v ***
// tap controller with test pin multiplexing for a programmable logic device
// What this block does
// - tap active while in factory default state, before user configuration
// - tap stays active in user mode unless the port preference disables it
// - with port disabled, the mux enable input becomes a dedicated select
// - disabled port: enable high gives tap function, low releases pins to gpio
// - mux enable acts only in user mode; otherwise it is plain user io
// - during tap programming, status pins follow scan cells, not progress logic
// - tdo driven only in shift-ir or shift-dr, otherwise high impedance
// - tms sampled on rising tck; next state from state and tms
// - shift in on rising tck, present tdo from falling tck
// - fully static: tck may stop high or low without losing state
// - all mandatory boundary-scan instructions implemented
// - configuration and programming accepted through tap instructions
// - undriven: tdi and tms read high, tdo floats high, mux enable low
`timescale 1ns/1ns
`include "tpm_defines.vh"
module tpm_tap_port #(
	parameter BSR_W = 8,
	parameter [31:0] ID_CODE = 32'h0000_1001
)(
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// mode and preference
	input wire user_mode,
	input wire port_pref_enable,
	input wire tap_pin_mux_enable,
	// test pins
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo,
	output reg tdo_oe_n,
	// boundary cells and status pin
	input wire [BSR_W-1:0] bsr_pin_in,
	output reg [BSR_W-1:0] bsr_pin_out,
	output reg bsr_drive,
	input wire done_internal,
	output reg done_pin,
	// pin routing and configuration
	output reg tap_pins_active,
	output reg [`TPM_CFG_W-1:0] cfg_word,
	output reg cfg_word_valid,
	output reg cfg_mode
);
// two flip-flops per test pin: tck, tms, tdi and the mux enable are asynchronous
reg [1:0] tck_s;
reg [1:0] tms_s;
reg [1:0] tdi_s;
reg [1:0] en_s;
reg tck_d;
reg [3:0] state;
reg [3:0] next_state;
reg [`TPM_IR_W-1:0] ir_sh;
reg [`TPM_IR_W-1:0] ir;
reg [31:0] dr_sh;
reg [BSR_W-1:0] bsr_sh;
reg shift_bit;
wire rise;
wire fall;
wire tap_on;
wire sel_bsr;
wire sel_cfg;

// edges take three ref_clk to be seen, so tck must stay below a quarter of ref_clk
assign rise = tck_s[1] & ~tck_d;
assign fall = ~tck_s[1] & tck_d;
assign tap_on = ~user_mode | port_pref_enable | en_s[1];
assign sel_bsr = (ir == `TPM_OP_EXTEST) | (ir == `TPM_OP_SAMPLE);
assign sel_cfg = (ir == `TPM_OP_CFG_PROGRAM);

// one step of the standard tap state diagram
function [3:0] tpm_next;
	input [3:0] s;
	input m;
	begin
		case (s)
			`TPM_ST_RESET: tpm_next = m ? `TPM_ST_RESET : `TPM_ST_IDLE;
			`TPM_ST_IDLE: tpm_next = m ? `TPM_ST_SEL_DR : `TPM_ST_IDLE;
			`TPM_ST_SEL_DR: tpm_next = m ? `TPM_ST_SEL_IR : `TPM_ST_CAP_DR;
			`TPM_ST_CAP_DR: tpm_next = m ? `TPM_ST_EX1_DR : `TPM_ST_SH_DR;
			`TPM_ST_SH_DR: tpm_next = m ? `TPM_ST_EX1_DR : `TPM_ST_SH_DR;
			`TPM_ST_EX1_DR: tpm_next = m ? `TPM_ST_UPD_DR : `TPM_ST_PA_DR;
			`TPM_ST_PA_DR: tpm_next = m ? `TPM_ST_EX2_DR : `TPM_ST_PA_DR;
			`TPM_ST_EX2_DR: tpm_next = m ? `TPM_ST_UPD_DR : `TPM_ST_SH_DR;
			`TPM_ST_UPD_DR: tpm_next = m ? `TPM_ST_SEL_DR : `TPM_ST_IDLE;
			`TPM_ST_SEL_IR: tpm_next = m ? `TPM_ST_RESET : `TPM_ST_CAP_IR;
			`TPM_ST_CAP_IR: tpm_next = m ? `TPM_ST_EX1_IR : `TPM_ST_SH_IR;
			`TPM_ST_SH_IR: tpm_next = m ? `TPM_ST_EX1_IR : `TPM_ST_SH_IR;
			`TPM_ST_EX1_IR: tpm_next = m ? `TPM_ST_UPD_IR : `TPM_ST_PA_IR;
			`TPM_ST_PA_IR: tpm_next = m ? `TPM_ST_EX2_IR : `TPM_ST_PA_IR;
			`TPM_ST_EX2_IR: tpm_next = m ? `TPM_ST_UPD_IR : `TPM_ST_SH_IR;
			`TPM_ST_UPD_IR: tpm_next = m ? `TPM_ST_SEL_DR : `TPM_ST_IDLE;
			default: tpm_next = `TPM_ST_RESET;
		endcase
	end
endfunction

// static: no timeout, state only moves on a rising tck edge or when the pins are released
always @*
begin
	next_state = state;
	if (rise)
		next_state = tpm_next(state, tms_s[1]);
end

// bit offered on tdo by the selected data register
always @*
begin
	case (ir)
		`TPM_OP_IDCODE: shift_bit = dr_sh[0];
		`TPM_OP_EXTEST: shift_bit = bsr_sh[0];
		`TPM_OP_SAMPLE: shift_bit = bsr_sh[0];
		`TPM_OP_CFG_PROGRAM: shift_bit = dr_sh[0];
		default: shift_bit = dr_sh[0];
	endcase
end

always @(posedge ref_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		tck_s <= 2'h0;
		tms_s <= 2'h3;
		tdi_s <= 2'h3;
		en_s <= 2'h0;
		tck_d <= 1'b0;
		state <= `TPM_ST_RESET;
		ir_sh <= `TPM_IR_RESET;
		ir <= `TPM_IR_RESET;
		dr_sh <= 32'h0;
		bsr_sh <= {BSR_W{1'b0}};
		tdo <= 1'b1;
		tdo_oe_n <= 1'b1;
		bsr_pin_out <= {BSR_W{1'b0}};
		bsr_drive <= 1'b0;
		done_pin <= 1'b0;
		tap_pins_active <= 1'b1;
		cfg_word <= {`TPM_CFG_W{1'b0}};
		cfg_word_valid <= 1'b0;
		cfg_mode <= 1'b0;
	end
	else
	begin
		tck_s <= {tck_s[0], tck};
		tms_s <= {tms_s[0], tms};
		tdi_s <= {tdi_s[0], tdi};
		en_s <= {en_s[0], tap_pin_mux_enable};
		tck_d <= tck_s[1];
		tap_pins_active <= tap_on;
		cfg_word_valid <= 1'b0;
		// released pins see no tap traffic
		if (!tap_on)
		begin
			// parked in reset so that a later grant starts clean
			state <= `TPM_ST_RESET;
			ir <= `TPM_IR_RESET;
			tdo_oe_n <= 1'b1;
		end
		else
		begin
			state <= next_state;
			if (rise)
			begin
				// capture and shift on rising tck
				case (state)
					`TPM_ST_RESET: ir <= `TPM_IR_RESET;
					`TPM_ST_CAP_IR: ir_sh <= `TPM_IR_RESET;
					`TPM_ST_SH_IR: ir_sh <= {tdi_s[1], ir_sh[`TPM_IR_W-1:1]};
					`TPM_ST_UPD_IR: ir <= ir_sh;
					`TPM_ST_CAP_DR:
					begin
						dr_sh <= (ir == `TPM_OP_IDCODE) ? ID_CODE : 32'h0;
						if (sel_bsr)
							bsr_sh <= bsr_pin_in;
					end
					`TPM_ST_SH_DR:
					begin
						dr_sh <= {tdi_s[1], dr_sh[31:1]};
						if (sel_bsr)
							bsr_sh <= {tdi_s[1], bsr_sh[BSR_W-1:1]};
						// bypass keeps a single bit in the path
						if (ir == `TPM_OP_BYPASS)
							dr_sh[0] <= tdi_s[1];
					end
					`TPM_ST_UPD_DR:
					begin
						if (ir == `TPM_OP_EXTEST)
							bsr_pin_out <= bsr_sh;
						if (sel_cfg)
						begin
							cfg_word <= dr_sh[`TPM_CFG_W-1:0];
							cfg_word_valid <= 1'b1;
						end
					end
					default: ;
				endcase
				if ((state == `TPM_ST_UPD_IR) && (ir_sh == `TPM_OP_CFG_ENABLE))
					cfg_mode <= 1'b1;
				if ((state == `TPM_ST_UPD_IR) && (ir_sh == `TPM_OP_CFG_DISABLE))
					cfg_mode <= 1'b0;
			end
			// tdo changes on falling tck, driven only while shifting
			if (fall)
			begin
				tdo_oe_n <= ~((state == `TPM_ST_SH_IR) | (state == `TPM_ST_SH_DR));
				tdo <= (state == `TPM_ST_SH_IR) ? ir_sh[0] : shift_bit;
			end
		end
		bsr_drive <= tap_on & (ir == `TPM_OP_EXTEST);
		// status pin follows its scan cell while programming over the tap
		done_pin <= (cfg_mode | (ir == `TPM_OP_EXTEST)) ? bsr_pin_out[0] : done_internal;
	end
end
endmodule // tpm_tap_port

// *** rtl/tpm_defines.vh ***
// constants for the tap port pin multiplexer
`ifndef TPM_DEFINES_VH
`define TPM_DEFINES_VH
`define TPM_IR_W 8
`define TPM_IR_RESET 8'h01
`define TPM_OP_EXTEST 8'h00
`define TPM_OP_IDCODE 8'h01
`define TPM_OP_SAMPLE 8'h02
`define TPM_OP_CFG_ENABLE 8'hc6
`define TPM_OP_CFG_PROGRAM 8'h70
`define TPM_OP_CFG_DISABLE 8'h26
`define TPM_OP_BYPASS 8'hff
`define TPM_CFG_W 32
`define TPM_ST_RESET 4'h0
`define TPM_ST_IDLE 4'h1
`define TPM_ST_SEL_DR 4'h2
`define TPM_ST_CAP_DR 4'h3
`define TPM_ST_SH_DR 4'h4
`define TPM_ST_EX1_DR 4'h5
`define TPM_ST_PA_DR 4'h6
`define TPM_ST_EX2_DR 4'h7
`define TPM_ST_UPD_DR 4'h8
`define TPM_ST_SEL_IR 4'h9
`define TPM_ST_CAP_IR 4'ha
`define TPM_ST_SH_IR 4'hb
`define TPM_ST_EX1_IR 4'hc
`define TPM_ST_PA_IR 4'hd
`define TPM_ST_EX2_IR 4'he
`define TPM_ST_UPD_IR 4'hf
`endif

// *** dv/tpm_tap_props.sv ***
// checker for the tap port pin multiplexer
`timescale 1ns/1ns
module tpm_tap_props #(parameter BSR_W = 8) (
	// watched ports
	input wire ref_clk,
	input wire arst_n,
	input wire tck,
	input wire user_mode,
	input wire port_pref_enable,
	input wire tdo,
	input wire tdo_oe_n,
	input wire [BSR_W-1:0] bsr_pin_out,
	input wire bsr_drive,
	input wire done_internal,
	input wire done_pin,
	input wire tap_pins_active,
	input wire cfg_word_valid,
	input wire cfg_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	tap_on_a: assert property ((!user_mode||port_pref_enable) [*3] |-> tap_pins_active)
		else $error("tap off");
	gpio_hiz_a: assert property (!tap_pins_active [*3] |-> tdo_oe_n)
		else $error("tdo driven");
	oe_cause_a: assert property ($fell(tdo_oe_n) |-> tap_pins_active)
		else $error("tdo on");
	done_scan_a: assert property ((cfg_mode||bsr_drive) [*2] |-> done_pin==$past(bsr_pin_out[0]))
		else $error("done not scan");
	done_int_a: assert property ((!(cfg_mode||bsr_drive)) [*2] |-> done_pin==$past(done_internal))
		else $error("done not internal");
	valid_pulse_a: assert property (cfg_word_valid |=> !cfg_word_valid)
		else $error("valid too long");
	bsr_hold_a: assert property ($changed(bsr_pin_out) |-> bsr_drive)
		else $error("cells moved");
	static_tap_a: assert property (($stable(tck)&&$stable(tap_pins_active)) [*8] |-> $stable(tdo))
		else $error("tdo moved");
endmodule // tpm_tap_props
bind tpm_tap_port tpm_tap_props #(.BSR_W(BSR_W)) u_props (.ref_clk(ref_clk), .arst_n(arst_n),
	.tck(tck), .user_mode(user_mode), .port_pref_enable(port_pref_enable), .tdo(tdo),
	.tdo_oe_n(tdo_oe_n), .bsr_pin_out(bsr_pin_out), .bsr_drive(bsr_drive),
	.done_internal(done_internal), .done_pin(done_pin), .tap_pins_active(tap_pins_active),
	.cfg_word_valid(cfg_word_valid), .cfg_mode(cfg_mode));

// *** dv/tpm_prog_model.sv ***
// behavioural scan programmer on the test pins
`timescale 1ns/1ns
module tpm_prog_model (
	// test pins
	output logic tck = 1'b0,
	output logic tms = 1'b1,
	output logic tdi = 1'b1,
	input wire tdo,
	input wire tdo_oe_n
);
	wire tdo_w = tdo_oe_n ? 1'b1 : tdo;
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		q = tdo_w;
		#80 tck = 1'b0;
	endtask
	task automatic rst5;
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] o);
		logic q;
		o = '0;
		step(1'b1, 1'b1, q);
		if (ir) step(1'b1, 1'b1, q);
		repeat (2) step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, d[i], q);
			o[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule // tpm_prog_model

// *** dv/tpm_tap_port_tb_top.sv ***
// self-checking bench for the tap port pin multiplexer
`timescale 1ns/1ns
`include "tpm_defines.vh"
module tpm_tap_port_tb_top;
	// arbitrary identity value
	localparam [31:0] ID = 32'h2a5c_0e13;
	logic ref_clk = 1'b0, arst_n = 1'b0, um = 1'b0, pe = 1'b0, me = 1'b0, di = 1'b0;
	wire tck, tms, tdi, tdo, oe_n, drv, done_pin, act, vld, cm;
	wire [7:0] bo;
	wire [31:0] cw;
	logic [31:0] r;
	int mismatches = 0, n_compared = 0, cyc = 0, n_valid = 0;
	tpm_prog_model m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(oe_n));
	tpm_tap_port #(.ID_CODE(ID)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .user_mode(um),
		.port_pref_enable(pe), .tap_pin_mux_enable(me), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe_n(oe_n), .bsr_pin_in(8'hc3), .bsr_pin_out(bo), .bsr_drive(drv),
		.done_internal(di), .done_pin(done_pin), .tap_pins_active(act), .cfg_word(cw),
		.cfg_word_valid(vld), .cfg_mode(cm));
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic sc(input logic ir, input int n, input logic [31:0] d);
		m.scan(ir, n, d, r);
	endtask
	task automatic t_id;
		m.rst5;
		sc(1, 8, `TPM_OP_IDCODE);
		chk(r[1:0], 2'b01);
		sc(0, 32, 0);
		chk(r, ID);
		chk(oe_n, 1'b1);
		sc(1, 8, `TPM_OP_BYPASS);
		sc(0, 2, 1);
		chk(r[1:0], 2'b10);
		m.step(1'b1, 1'b1, r[0]);
		repeat (2) m.step(1'b0, 1'b1, r[0]);
		m.rst5;
		sc(0, 32, 0);
		chk(r, ID);
	endtask
	task automatic t_bsr;
		sc(1, 8, `TPM_OP_SAMPLE);
		sc(0, 8, 8'h5a);
		chk(r[7:0], 8'hc3);
		sc(1, 8, `TPM_OP_EXTEST);
		sc(0, 8, 8'h96);
		di = 1'b1;
		chk({drv, bo}, 9'h196);
		#100 chk(done_pin, 1'b0);
		sc(1, 8, `TPM_OP_CFG_ENABLE);
		sc(1, 8, `TPM_OP_CFG_PROGRAM);
		sc(0, 32, 32'hc0de_5a17);
		chk({cm, cw}, 33'h1c0de5a17);
		chk(n_valid, 1);
		sc(1, 8, `TPM_OP_CFG_DISABLE);
		chk({cm, done_pin}, 2'b01);
	endtask
	task automatic t_mux;
		for (int v = 0; v < 8; v++)
		begin
			@(negedge ref_clk);
			{um, pe, me} = v[2:0];
			#200 chk(act, !v[2] || v[1] || v[0]);
		end
		{um, pe, me} = 3'b100;
		sc(0, 32, 0);
		chk({r, oe_n}, 33'h1ffffffff);
		me = 1'b1;
		m.rst5;
		sc(0, 32, 0);
		chk(r, ID);
	endtask
	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (vld)
			n_valid++;
		if (cyc == 40000)
		begin
			mismatches++;
			finish_test;
		end
	end
	initial
	begin
		repeat (6) @(negedge ref_clk);
		arst_n = 1'b1;
		t_id;
		t_bsr;
		t_mux;
		finish_test;
	end
endmodule // tpm_tap_port_tb_top
